// file: hcevg_params.svh
// Purpose: Constants for the host controller event generator.
// Assumes: Included by every design file that needs codes or sizes.
// Notes:   Multi-byte fields leave the block least significant byte first.
`ifndef HCEVG_PARAMS_SVH
`define HCEVG_PARAMS_SVH

`define HCEVG_CODE_BASE        8'h16
`define HCEVG_CODE_PIN_REQ     8'h16
`define HCEVG_CODE_KEY_REQ     8'h17
`define HCEVG_CODE_KEY_NOTIF   8'h18
`define HCEVG_CODE_LOOPBACK    8'h19
`define HCEVG_CODE_OVERFLOW    8'h1a
`define HCEVG_CODE_MAX_SLOTS   8'h1b
`define HCEVG_CODE_CLK_OFFSET  8'h1c

`define HCEVG_LEN_ADDR         8'h06
`define HCEVG_LEN_KEY_NOTIF    8'h16
`define HCEVG_LEN_OVERFLOW     8'h01
`define HCEVG_LEN_MAX_SLOTS    8'h03
`define HCEVG_LEN_CLK_OFFSET   8'h05

`define HCEVG_LB_MAX_PAYLOAD   255
`define HCEVG_CMD_HDR_BYTES    3
`define HCEVG_LB_MAX_PARAMS    252

`define HCEVG_LINK_SYNC        8'h00
`define HCEVG_LINK_ASYNC       8'h01

`define HCEVG_HANDLE_MAX_VALID 12'heff
`define HCEVG_OFFS_DIFF_MSB    16
`define HCEVG_OFFS_DIFF_LSB    2
`define HCEVG_PAYLOAD_BITS     176

`endif

// file: hcevg_pkg.sv
// Purpose: Types shared by the event generator modules.
// Assumes: Constants live in hcevg_params.svh.
// Notes:   Source order follows ascending event code.
package hcevg_pkg;
    typedef enum logic {
        HCEVG_S_IDLE,
        HCEVG_S_SEND
    } hcevg_state_t;
endpackage

// file: hcevg_lb_if.sv
// Purpose: Carrier between the framer and the loopback buffer.
// Assumes: One command held at a time.
// Notes:   ctl side is the framer, store side the buffer.
interface hcevg_lb_if;
    logic [7:0] wr_byte;
    logic       wr_valid;
    logic       wr_last;
    logic       wr_ready;
    logic       pkt_ready;
    logic [7:0] pkt_len;
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic       release_pkt;

    modport ctl (
        output wr_byte, wr_valid, wr_last, rd_idx, release_pkt,
        input  wr_ready, pkt_ready, pkt_len, rd_byte
    );
    modport store (
        input  wr_byte, wr_valid, wr_last, rd_idx, release_pkt,
        output wr_ready, pkt_ready, pkt_len, rd_byte
    );
endinterface

// file: hcevg_lb_buf.sv
// Purpose: Holds one host command for echo, truncated to the payload cap.
// Assumes: Bytes arrive header first; wr_last marks the final byte.
// Notes:   Bytes past the cap are accepted and dropped, so the host
//          never stalls on an oversize command.
`include "hcevg_params.svh"
module hcevg_lb_buf #(
    parameter int DEPTH = `HCEVG_LB_MAX_PAYLOAD
) (
    input  wire logic   clk_sys_in,
    input  wire logic   rst_in,
    hcevg_lb_if.store   lb
);
    logic [7:0] mem [DEPTH];
    logic [7:0] cnt_reg;
    logic       ready_reg;
    logic       wr_ready_reg;
    logic       take_w;
    logic       room_w;

    assign take_w      = lb.wr_valid & wr_ready_reg;
    assign room_w      = 32'(cnt_reg) < DEPTH;
    assign lb.wr_ready = wr_ready_reg;
    assign lb.pkt_ready = ready_reg;
    assign lb.pkt_len  = cnt_reg;
    assign lb.rd_byte  = mem[lb.rd_idx];

    always_ff @(posedge clk_sys_in) begin
        if (take_w && room_w) begin
            mem[cnt_reg] <= lb.wr_byte;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg      <= 8'h00;
            ready_reg    <= 1'b0;
            wr_ready_reg <= 1'b1;
        end else if (lb.release_pkt) begin
            cnt_reg      <= 8'h00;
            ready_reg    <= 1'b0;
            wr_ready_reg <= 1'b1;
        end else if (take_w) begin
            if (room_w) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            if (lb.wr_last) begin
                ready_reg    <= 1'b1;
                wr_ready_reg <= 1'b0;
            end
        end
    end
endmodule

// file: hcevg_event_gen.sv
// Purpose: Frames controller-to-host event packets, codes 16h..1Ch.
// Assumes: Event strobes are one-cycle pulses with their fields valid
//          in the same cycle; mask_in, lb_mode_in and cmd_skip_in hold
//          steady across a command.
// Notes:   One packet at a time, lowest code first; a repeat strobe
//          while pending replaces the held fields.
`include "hcevg_params.svh"
module hcevg_event_gen
    import hcevg_pkg::*;
#(
    parameter int LB_DEPTH = `HCEVG_LB_MAX_PAYLOAD
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_in,
    input  wire logic [6:0]   mask_in,
    input  wire logic         pin_req_in,
    input  wire logic [47:0]  pin_addr_in,
    input  wire logic         key_req_in,
    input  wire logic [47:0]  key_addr_in,
    input  wire logic         new_key_in,
    input  wire logic [47:0]  new_key_addr_in,
    input  wire logic [127:0] new_key_val_in,
    input  wire logic         ovf_in,
    input  wire logic         ovf_async_in,
    input  wire logic         slots_chg_in,
    input  wire logic [11:0]  slots_handle_in,
    input  wire logic [7:0]   slots_val_in,
    input  wire logic         conn_any_in,
    input  wire logic         offs_done_in,
    input  wire logic [7:0]   offs_status_in,
    input  wire logic [11:0]  offs_handle_in,
    input  wire logic [27:0]  clk_diff_in,
    input  wire logic         lb_mode_in,
    input  wire logic [7:0]   cmd_byte_in,
    input  wire logic         cmd_valid_in,
    input  wire logic         cmd_last_in,
    input  wire logic         cmd_skip_in,
    output logic              cmd_ready_out,
    output logic [7:0]        evt_byte_out,
    output logic              evt_valid_out,
    output logic              evt_last_out,
    input  wire logic         evt_ready_in,
    output logic              pin_absent_out,
    output logic              key_absent_out
);
    hcevg_lb_if lb_if ();

    hcevg_lb_buf #(
        .DEPTH (LB_DEPTH)
    ) u_lb_buf (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .lb         (lb_if)
    );

    hcevg_state_t state_reg;
    hcevg_state_t state_next;
    logic [5:0]   pend_reg;
    logic [5:0]   pend_next;
    logic [47:0]  pin_addr_reg;
    logic [47:0]  key_addr_reg;
    logic [175:0] notif_reg;
    logic [7:0]   ovf_type_reg;
    logic [23:0]  slots_reg;
    logic [39:0]  offs_reg;
    logic [175:0] snap_reg;
    logic [7:0]   code_reg;
    logic [7:0]   len_reg;
    logic [8:0]   idx_reg;
    logic         loop_reg;
    logic [7:0]   evt_byte_reg;
    logic         evt_valid_reg;
    logic         evt_last_reg;
    logic         pin_absent_reg;
    logic         key_absent_reg;

    // Command path into the echo store
    wire logic echo_w = lb_mode_in & ~cmd_skip_in;
    assign lb_if.wr_byte  = cmd_byte_in;
    assign lb_if.wr_valid = cmd_valid_in & echo_w;
    assign lb_if.wr_last  = cmd_last_in;
    // Non-echoed commands still see the store's ready; they only wait
    // while an echo is queued, which keeps command order intact.
    assign cmd_ready_out  = lb_if.wr_ready;

    // Qualified event strobes
    wire logic slots_ok_w = slots_chg_in & conn_any_in
        & (slots_handle_in <= `HCEVG_HANDLE_MAX_VALID);
    wire logic offs_ok_w = offs_done_in
        & (offs_handle_in <= `HCEVG_HANDLE_MAX_VALID);
    wire logic [5:0] raw_w = {offs_ok_w, slots_ok_w, ovf_in,
                              new_key_in, key_req_in, pin_req_in};
    wire logic [5:0] req_w = raw_w & ~{mask_in[6:4], mask_in[2:0]};

    // Pick lowest code pending; loopback sits in slot 3
    wire logic lb_avail_w = lb_if.pkt_ready & ~mask_in[3];
    wire logic [6:0] avail_w = {pend_reg[5:3], lb_avail_w, pend_reg[2:0]};
    wire logic [6:0] pick_w = avail_w & (~avail_w + 7'h01);
    wire logic [2:0] pick_idx_w =
        pick_w[0] ? 3'd0 : pick_w[1] ? 3'd1 : pick_w[2] ? 3'd2 :
        pick_w[3] ? 3'd3 : pick_w[4] ? 3'd4 : pick_w[5] ? 3'd5 : 3'd6;
    wire logic idle_w  = state_reg == HCEVG_S_IDLE;
    wire logic start_w = idle_w & (|avail_w);
    wire logic [5:0] clr_w = start_w ? {pick_w[6:4], pick_w[2:0]} : 6'h00;

    // Set beats clear when a strobe meets its own dispatch
    assign pend_next = req_w | (pend_reg & ~clr_w);

    wire logic [7:0] pick_len_w =
        (pick_idx_w <= 3'd1) ? `HCEVG_LEN_ADDR :
        (pick_idx_w == 3'd2) ? `HCEVG_LEN_KEY_NOTIF :
        (pick_idx_w == 3'd3) ? lb_if.pkt_len :
        (pick_idx_w == 3'd4) ? `HCEVG_LEN_OVERFLOW :
        (pick_idx_w == 3'd5) ? `HCEVG_LEN_MAX_SLOTS :
                               `HCEVG_LEN_CLK_OFFSET;
    wire logic [175:0] pick_pay_w =
        (pick_idx_w == 3'd0) ? 176'(pin_addr_reg) :
        (pick_idx_w == 3'd1) ? 176'(key_addr_reg) :
        (pick_idx_w == 3'd2) ? notif_reg :
        (pick_idx_w == 3'd4) ? 176'(ovf_type_reg) :
        (pick_idx_w == 3'd5) ? 176'(slots_reg) :
        (pick_idx_w == 3'd6) ? 176'(offs_reg) : 176'h0;

    // Byte stream: code, length, then parameters
    wire logic step_w = (state_reg == HCEVG_S_SEND)
        & (~evt_valid_reg | evt_ready_in);
    wire logic [8:0] par_idx_w = idx_reg - 9'd2;
    wire logic [175:0] snap_sh_w = snap_reg >> {par_idx_w[4:0], 3'b000};
    wire logic [7:0] cur_byte_w =
        (idx_reg == 9'd0) ? code_reg :
        (idx_reg == 9'd1) ? len_reg :
        loop_reg ? lb_if.rd_byte : snap_sh_w[7:0];
    wire logic last_w = idx_reg == ({1'b0, len_reg} + 9'd1);

    assign lb_if.rd_idx = par_idx_w[7:0];
    // Masked echo is discarded unsent so the host is not held up
    assign lb_if.release_pkt = (step_w & last_w & loop_reg)
        | (idle_w & lb_if.pkt_ready & mask_in[3]);

    // Field capture, little-endian packing; one field per block
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_addr_reg <= 48'h0;
        end else if (pin_req_in) begin
            pin_addr_reg <= pin_addr_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            key_addr_reg <= 48'h0;
        end else if (key_req_in) begin
            key_addr_reg <= key_addr_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            notif_reg <= 176'h0;
        end else if (new_key_in) begin
            notif_reg <= {new_key_val_in, new_key_addr_in};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ovf_type_reg <= 8'h00;
        end else if (ovf_in) begin
            ovf_type_reg <= ovf_async_in ? `HCEVG_LINK_ASYNC
                                         : `HCEVG_LINK_SYNC;
        end
    end

    // Dropped strobes leave a pending packet's fields alone
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            slots_reg <= 24'h0;
        end else if (slots_ok_w) begin
            // Handle source is the async data link table
            slots_reg <= {slots_val_in, 4'h0, slots_handle_in};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            offs_reg <= 40'h0;
        end else if (offs_ok_w) begin
            offs_reg <= {1'b0,
                clk_diff_in[`HCEVG_OFFS_DIFF_MSB:`HCEVG_OFFS_DIFF_LSB],
                4'h0, offs_handle_in, offs_status_in};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pend_reg <= 6'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // Masked requests answer "nothing held" on the next cycle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_absent_reg <= 1'b0;
        end else begin
            pin_absent_reg <= pin_req_in & mask_in[0];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            key_absent_reg <= 1'b0;
        end else begin
            key_absent_reg <= key_req_in & mask_in[1];
        end
    end

    // Packet dispatch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HCEVG_S_IDLE: begin
                if (start_w) begin
                    state_next = HCEVG_S_SEND;
                end
            end
            HCEVG_S_SEND: begin
                if (step_w && last_w) begin
                    state_next = HCEVG_S_IDLE;
                end
            end
            default: begin
                state_next = HCEVG_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= HCEVG_S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Snapshot frees the field registers for the next strobe at once
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            snap_reg <= 176'h0;
            code_reg <= 8'h00;
            len_reg  <= 8'h00;
            loop_reg <= 1'b0;
        end else if (start_w) begin
            snap_reg <= pick_pay_w;
            code_reg <= `HCEVG_CODE_BASE + {5'h00, pick_idx_w};
            len_reg  <= pick_len_w;
            loop_reg <= pick_idx_w == 3'd3;
        end
    end

    // Byte index: 0 code, 1 length, then parameters
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            idx_reg <= 9'd0;
        end else if (start_w) begin
            idx_reg <= 9'd0;
        end else if (step_w) begin
            idx_reg <= idx_reg + 9'd1;
        end
    end

    // Output register; holds a byte until the host takes it
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            evt_byte_reg <= 8'h00;
        end else if (step_w) begin
            evt_byte_reg <= cur_byte_w;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            evt_valid_reg <= 1'b0;
            evt_last_reg  <= 1'b0;
        end else if (step_w) begin
            evt_valid_reg <= 1'b1;
            evt_last_reg  <= last_w;
        end else if (evt_ready_in) begin
            evt_valid_reg <= 1'b0;
            evt_last_reg  <= 1'b0;
        end
    end

    assign evt_byte_out   = evt_byte_reg;
    assign evt_valid_out  = evt_valid_reg;
    assign evt_last_out   = evt_last_reg;
    assign pin_absent_out = pin_absent_reg;
    assign key_absent_out = key_absent_reg;
endmodule

// file: hcevg_host_model.sv
// Purpose: Host-side event sink that records every accepted byte.
// Assumes: slow_in asks for ready on every other cycle only.
// Notes:   Ready moves on the edge, never between edges.
module hcevg_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] evt_byte_in,
    input  wire logic       evt_valid_in,
    input  wire logic       evt_last_in,
    input  wire logic       slow_in,
    output logic            evt_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic       last_q[$];
    // Takes an event on any edge where ready is high; with slow_in set, ready is high every other cycle only
    always @(posedge clk_sys_in) begin
        if (!rst_in && evt_valid_in && evt_ready_out) begin
            rx_q.push_back(evt_byte_in);
            last_q.push_back(evt_last_in);
        end
        evt_ready_out <= rst_in ? 1'h0 : (!slow_in || !evt_ready_out);
    end
endmodule

// file: hcevg_event_gen_monitor.sv
// Purpose: Port-level checks on the event byte stream.
// Assumes: Byte index is tracked from accepted bytes only.
// Notes:   Field checks key off the code byte of the packet.
module hcevg_event_gen_monitor (
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic [6:0] mask_in,
    input wire logic       pin_req_in,
    input wire logic       key_req_in,
    input wire logic       lb_mode_in,
    input wire logic       cmd_valid_in,
    input wire logic       cmd_last_in,
    input wire logic       cmd_skip_in,
    input wire logic       cmd_ready_out,
    input wire logic [7:0] evt_byte_out,
    input wire logic       evt_valid_out,
    input wire logic       evt_last_out,
    input wire logic       evt_ready_in,
    input wire logic       pin_absent_out,
    input wire logic       key_absent_out
);
    logic [8:0] idx_reg;
    logic [7:0] code_reg;
    logic [7:0] len_reg;
    wire        taken  = evt_valid_out & evt_ready_in;
    wire        at_len = evt_valid_out && idx_reg == 9'h001;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            idx_reg  <= 9'h000;
            code_reg <= 8'h00;
            len_reg  <= 8'h00;
        end else if (taken) begin
            idx_reg <= evt_last_out ? 9'h000 : idx_reg + 9'h001;
            if (idx_reg == 9'h000) code_reg <= evt_byte_out;
            if (idx_reg == 9'h001) len_reg <= evt_byte_out;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    chk_valid_hold:
    assert property (evt_valid_out && !evt_ready_in |=> evt_valid_out
        && $stable(evt_byte_out) && $stable(evt_last_out))
        else $error("event byte changed while stalled");
    chk_first_code:
    assert property (evt_valid_out && idx_reg == 9'h000 |->
        evt_byte_out inside {[8'h16:8'h1c]}) else $error("bad event code");
    chk_last_count:
    assert property (evt_valid_out && evt_last_out |-> (idx_reg == 9'h001
        ? evt_byte_out == 8'h00 : idx_reg == {1'h0, len_reg} + 9'h001))
        else $error("last flag off the length");
    chk_addr_len:
    assert property (at_len && code_reg inside {8'h16, 8'h17} |->
        evt_byte_out == 8'h06) else $error("request length wrong");
    chk_notif_len:
    assert property (at_len && code_reg == 8'h18 |-> evt_byte_out == 8'h16)
        else $error("notification length wrong");
    chk_fixed_len:
    assert property (at_len && code_reg inside {[8'h1a:8'h1c]} |->
        evt_byte_out == code_reg - 8'h19 + (code_reg == 8'h1c ? 8'h02 : 8'h00)
        + (code_reg == 8'h1b ? 8'h01 : 8'h00)) else $error("length wrong");
    chk_link_type:
    assert property (evt_valid_out && idx_reg == 9'h002 && code_reg == 8'h1a
        |-> evt_byte_out <= 8'h01) else $error("reserved link type");
    chk_handle_top:
    assert property (evt_valid_out && ((code_reg == 8'h1b && idx_reg == 9'h003)
        || (code_reg == 8'h1c && idx_reg == 9'h004)) |->
        evt_byte_out[7:4] == 4'h0) else $error("handle upper nibble set");
    chk_offs_rsvd:
    assert property (evt_valid_out && code_reg == 8'h1c && idx_reg == 9'h006
        |-> !evt_byte_out[7]) else $error("offset bit 15 set");
    chk_pin_absent:
    assert property (pin_req_in && mask_in[0] |=> pin_absent_out)
        else $error("no pin absent pulse");
    chk_key_absent:
    assert property (key_req_in && mask_in[1] |=> key_absent_out)
        else $error("no key absent pulse");
    chk_echo_stall:
    assert property (cmd_valid_in && cmd_ready_out && cmd_last_in && lb_mode_in
        && !cmd_skip_in && !mask_in[3] |=> !cmd_ready_out)
        else $error("ready held after echoed command");
    cover property (taken && evt_last_out && code_reg == 8'h19);
    cover property (evt_valid_out && !evt_ready_in);
    cover property (pin_absent_out);
endmodule
bind hcevg_event_gen hcevg_event_gen_monitor i_hcevg_event_gen_monitor (
    .clk_sys_in, .rst_in, .mask_in, .pin_req_in, .key_req_in, .lb_mode_in,
    .cmd_valid_in, .cmd_last_in, .cmd_skip_in, .cmd_ready_out, .evt_byte_out,
    .evt_valid_out, .evt_last_out, .evt_ready_in, .pin_absent_out,
    .key_absent_out);

// file: hcevg_event_gen_bench.sv
// Purpose: Self-checking bench for the event generator.
// Assumes: Host model keeps every accepted event byte in rx_q.
// Notes:   Inputs move 1 ns after the rising edge.
module hcevg_event_gen_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys_in, rst_in, slow, pin_req_in, key_req_in;
    logic         new_key_in, ovf_in, ovf_async_in, slots_chg_in;
    logic         conn_any_in, offs_done_in, lb_mode_in, cmd_valid_in;
    logic         cmd_last_in, cmd_skip_in, cmd_ready_out, evt_valid_out;
    logic         evt_last_out, evt_ready_in, pin_absent_out, key_absent_out;
    logic [6:0]   mask_in;
    logic [47:0]  pin_addr_in, key_addr_in, new_key_addr_in;
    logic [127:0] new_key_val_in;
    logic [11:0]  slots_handle_in, offs_handle_in;
    logic [7:0]   slots_val_in, offs_status_in, cmd_byte_in, evt_byte_out;
    logic [27:0]  clk_diff_in;
    logic [7:0]   exp_q[$];
    int           errors = 0;
    int           total_checks = 0;
    hcevg_event_gen i_hcevg_event_gen (.clk_sys_in, .rst_in, .mask_in,
        .pin_req_in, .pin_addr_in, .key_req_in, .key_addr_in, .new_key_in,
        .new_key_addr_in, .new_key_val_in, .ovf_in, .ovf_async_in,
        .slots_chg_in, .slots_handle_in, .slots_val_in, .conn_any_in,
        .offs_done_in, .offs_status_in, .offs_handle_in, .clk_diff_in,
        .lb_mode_in, .cmd_byte_in, .cmd_valid_in, .cmd_last_in, .cmd_skip_in,
        .cmd_ready_out, .evt_byte_out, .evt_valid_out, .evt_last_out,
        .evt_ready_in, .pin_absent_out, .key_absent_out);
    hcevg_host_model i_hcevg_host_model (.clk_sys_in, .rst_in,
        .evt_byte_in(evt_byte_out), .evt_valid_in(evt_valid_out),
        .evt_last_in(evt_last_out), .slow_in(slow),
        .evt_ready_out(evt_ready_in));
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic add_le(input logic [127:0] v, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(v[8*i +: 8]);
    endtask
    task automatic wait_ok(input int k, input string what);
        if (k > 3000) begin
            check(what, 16'h0000, 16'h0001);
            test_done();
        end
    endtask
    // Waits for the expected bytes, then a few idle cycles for extras
    task automatic expect_pkt(input string what);
        int k;
        int nxt;
        int e;
        k = 0;
        nxt = 0;
        while (i_hcevg_host_model.rx_q.size() < exp_q.size()) begin
            step(1);
            k++;
            wait_ok(k, what);
        end
        step(6);
        check(what, 16'(i_hcevg_host_model.rx_q.size()),
              16'(exp_q.size()));
        foreach (exp_q[i]) begin
            check(what, i_hcevg_host_model.rx_q[i], exp_q[i]);
            // End flag only on the byte the length byte points at
            e = nxt + exp_q[nxt + 1] + 1;
            check({what, " end"}, 16'(i_hcevg_host_model.last_q[i]),
                  16'(i == e));
            if (i == e) nxt = i + 1;
        end
        i_hcevg_host_model.rx_q.delete();
        i_hcevg_host_model.last_q.delete();
        exp_q.delete();
    endtask
    task automatic t_requests();
        pin_addr_in = 48'h0a0b0c0d0e0f;
        key_addr_in = 48'h112233445566;
        for (int t = 0; t < 2; t++) begin
            mask_in = t ? 7'h03 : 7'h00;
            pin_req_in = 1'h1;
            key_req_in = 1'h1;
            step(1);
            pin_req_in = 1'h0;
            key_req_in = 1'h0;
            check("pin absent", pin_absent_out, 16'(t));
            check("key absent", key_absent_out, 16'(t));
            if (t == 0) add_le({key_addr_in, 16'h0617, pin_addr_in, 16'h0616},
                               16);
            expect_pkt("requests");
        end
        mask_in = 7'h00;
        $display("Test requests done");
    endtask
    task automatic t_new_key();
        slow = 1'h1;
        new_key_addr_in = 48'ha1a2a3a4a5a6;
        new_key_val_in = 128'h00112233445566778899aabbccddeeff;
        new_key_in = 1'h1;
        step(1);
        new_key_in = 1'h0;
        add_le({new_key_addr_in, 16'h1618}, 8);
        add_le(new_key_val_in, 16);
        expect_pkt("key notification");
        slow = 1'h0;
        $display("Test key notification done");
    endtask
    task automatic t_fields();
        logic [11:0] hs[3];
        hs = '{12'heff, 12'hf00, 12'h123};
        for (int t = 0; t < 2; t++) begin
            ovf_async_in = t[0];
            ovf_in = 1'h1;
            step(1);
            ovf_in = 1'h0;
            add_le({8'(t), 16'h011a}, 3);
            expect_pkt("overflow");
        end
        slots_val_in = 8'h05;
        for (int t = 0; t < 3; t++) begin
            slots_handle_in = hs[t];
            conn_any_in = (t != 2);
            slots_chg_in = 1'h1;
            step(1);
            slots_chg_in = 1'h0;
            if (t == 0) add_le({8'h05, 16'h0eff, 16'h031b}, 5);
            expect_pkt("max slots");
        end
        for (int t = 0; t < 3; t++) begin
            offs_handle_in = (t == 2) ? 12'hf00 : 12'h0a5;
            offs_status_in = t ? 8'h05 : 8'h00;
            clk_diff_in = 28'hfedcba9 + 28'(t);
            offs_done_in = 1'h1;
            step(1);
            offs_done_in = 1'h0;
            if (t < 2) add_le({1'h0, clk_diff_in[16:2], 4'h0, offs_handle_in,
                    offs_status_in, 16'h051c}, 7);
            expect_pkt("clock offset");
        end
        $display("Test field events done");
    endtask
    task automatic send_cmd(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            cmd_byte_in = 8'(i + 3);
            cmd_valid_in = 1'h1;
            cmd_last_in = (i == n - 1);
            k = 0;
            while (cmd_ready_out !== 1'h1) begin
                step(1);
                k++;
                wait_ok(k, "command ready");
            end
            step(1);
        end
        cmd_valid_in = 1'h0;
        cmd_last_in = 1'h0;
    endtask
    task automatic t_loopback();
        lb_mode_in = 1'h1;
        send_cmd(260);
        add_le(16'hff19, 2);
        for (int i = 0; i < 255; i++) exp_q.push_back(8'(i + 3));
        expect_pkt("echo capped");
        cmd_skip_in = 1'h1;
        send_cmd(4);
        expect_pkt("excepted command");
        cmd_skip_in = 1'h0;
        lb_mode_in = 1'h0;
        $display("Test loopback done");
    endtask
    task automatic t_masked();
        mask_in = 7'h7c;
        conn_any_in = 1'h1;
        lb_mode_in = 1'h1;
        {new_key_in, ovf_in, slots_chg_in, offs_done_in} = 4'hf;
        step(1);
        {new_key_in, ovf_in, slots_chg_in, offs_done_in} = 4'h0;
        send_cmd(3);
        expect_pkt("masked events");
        check("ready back", cmd_ready_out, 16'h0001);
        {lb_mode_in, mask_in} = '0;
        $display("Test masked events done");
    endtask
    initial begin
        {clk_sys_in, slow, pin_req_in, key_req_in, new_key_in, ovf_in,
         ovf_async_in, slots_chg_in, conn_any_in, offs_done_in, lb_mode_in,
         cmd_valid_in, cmd_last_in, cmd_skip_in, mask_in, pin_addr_in,
         key_addr_in, new_key_addr_in, new_key_val_in, slots_handle_in,
         offs_handle_in, slots_val_in, offs_status_in, cmd_byte_in,
         clk_diff_in} = '0;
        rst_in = 1'h1;
        step(20);
        rst_in = 1'h0;
        step(2);
        t_requests();
        t_new_key();
        t_fields();
        t_loopback();
        t_masked();
        test_done();
    end
endmodule
